// >>> ldss_sequencer.sv
`default_nettype none
`include "ldss_params.svh"
// Notes on behaviour
// - Word-arrival strobe inserts a single one into the first chain stage.
// - Token advances one stage per 1 MHz tick; sequence-done at completion.
// - Each step pulse is stage output gated with the tick, one per period.
// - Chain can hold, jump back from step 3 to step 2, or exit at step 4.
// - Non-character words use common step 2..4; character sequence starts at step 4.
// - Except non-zero-length line words and character data words, processing finishes at step 4.
// - Copies from the input word move only the field the target needs.
// - Twin X and Y sections with 9-bit final, increment registers and adder.
// - Final register loads from its word field or its adder, by gating.
// - Increment register loads from present position or its adder.
// - Adder operand is increment register true or complemented, by gating.
// - Present X and Y positions can step up or down by one.
// - Each section compares its final register with its word field.
// - Step 0 loads the word; upper half X end, lower half Y end.
// - Step 1 checks the word, bumps the word counter, continues line mode.
// - Step 2 clears finals, selects complement operand and position source.
// - Step 3 writes or erases the panel point at present position.
// - Next step loads word halves into finals; zero-length line ends there.
module ldss_sequencer (
	input  wire logic                 clk_sys,
	input  wire logic                 rstn,
	input  wire logic                 word_arrival,
	input  wire ldss_pkg::ldss_word_t word_in,
	input  wire logic                 line_mode,
	input  wire logic                 char_mode,
	input  wire logic                 write_mode,
	input  wire logic                 hold_step,
	input  wire logic                 repeat_step,
	output logic                      busy,
	output logic [`LDSS_STAGES-1:0]   chain_phase_pulse,
	output logic                      seq_done,
	output logic                      word_error,
	output logic [`LDSS_WC_W-1:0]     word_counter,
	output logic                      panel_write,
	output logic                      panel_erase,
	output logic                      char_start,
	output logic                      line_start,
	output ldss_pkg::ldss_word_t      word_reg,
	output ldss_pkg::ldss_coord_t     pos_x,
	output ldss_pkg::ldss_coord_t     pos_y,
	output ldss_pkg::ldss_coord_t     fin_x,
	output ldss_pkg::ldss_coord_t     fin_y,
	output ldss_pkg::ldss_coord_t     inc_x,
	output ldss_pkg::ldss_coord_t     inc_y
);
	import ldss_pkg::*;

	localparam int DIV_W = $clog2(`LDSS_STEP_DIV);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(`LDSS_STEP_DIV - 1);

	logic [DIV_W-1:0]     div_cnt;
	logic [DIV_W-1:0]     next_div_cnt;
	logic                 tick;
	ldss_chain_t          chain;
	ldss_chain_t          next_chain;
	logic                 pend;
	logic                 next_pend;
	ldss_word_t           next_word_reg;
	logic [`LDSS_WC_W-1:0] next_word_counter;
	logic                 next_word_error;
	logic                 next_seq_done;
	logic                 next_panel_write;
	logic                 next_panel_erase;
	logic                 next_char_start;
	logic                 next_line_start;
	logic                 x_eq;
	logic                 y_eq;
	logic                 zero_len;

	// Step rate divider; one-cycle tick every microsecond
	always_comb begin
		next_div_cnt = (div_cnt == DIV_LAST) ? '0 : div_cnt + 1'b1;
		tick = (div_cnt == DIV_LAST);
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= next_div_cnt;
		end
	end

	// Step pulse per stage, qualified by the tick
	generate
		for (genvar s = 0; s < `LDSS_STAGES; s++) begin : g_pulse
			assign chain_phase_pulse[s] = chain[s] & tick;
		end
	endgenerate

	assign busy = |chain | pend;
	assign zero_len = x_eq & y_eq;

	// Chain control: strobe waits for the next tick so step 0 is a full period
	always_comb begin
		next_pend = pend;
		next_chain = chain;
		if (word_arrival) begin
			next_pend = 1'b1;
		end
		if (tick) begin
			next_chain = '0;
			if (pend || word_arrival) begin
				next_chain[0] = 1'b1;
				next_pend = 1'b0;
			end else if (hold_step && |chain) begin
				next_chain = chain;
			end else if (repeat_step && chain[3]) begin
				next_chain[2] = 1'b1;
			end else if (chain[4]) begin
				// Every exit, a zero-length line too, leaves from stage 4
				next_chain = '0;
			end else begin
				next_chain = ldss_chain_t'({chain[`LDSS_STAGES-2:0], 1'b0});
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			chain <= '0;
			pend <= 1'b0;
		end else begin
			chain <= next_chain;
			pend <= next_pend;
		end
	end

	// Step actions
	always_comb begin
		next_word_reg = word_reg;
		next_word_counter = word_counter;
		next_word_error = word_error;
		next_seq_done = 1'b0;
		next_panel_write = 1'b0;
		next_panel_erase = 1'b0;
		next_char_start = 1'b0;
		next_line_start = 1'b0;
		if (chain_phase_pulse[0]) begin
			next_word_reg = word_in;
		end
		if (chain_phase_pulse[1]) begin
			next_word_error = line_mode & char_mode;
			next_word_counter = word_counter + 1'b1;
		end
		if (chain_phase_pulse[3]) begin
			next_panel_write = write_mode;
			next_panel_erase = ~write_mode;
		end
		if (chain_phase_pulse[4] && !hold_step) begin
			if (line_mode && zero_len) begin
				next_seq_done = 1'b1;
			end else if (line_mode) begin
				next_line_start = 1'b1;
			end else if (char_mode) begin
				next_char_start = 1'b1;
			end else begin
				next_seq_done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			word_reg <= '0;
			word_counter <= `LDSS_WC_RST;
			word_error <= 1'b0;
			seq_done <= 1'b0;
			panel_write <= 1'b0;
			panel_erase <= 1'b0;
			char_start <= 1'b0;
			line_start <= 1'b0;
		end else begin
			word_reg <= next_word_reg;
			word_counter <= next_word_counter;
			word_error <= next_word_error;
			seq_done <= next_seq_done;
			panel_write <= next_panel_write;
			panel_erase <= next_panel_erase;
			char_start <= next_char_start;
			line_start <= next_line_start;
		end
	end

	// Only the needed field of the word reaches each section
	ldss_section u_x (
		.clk_sys        (clk_sys),
		.rstn           (rstn),
		.word_field     (word_reg[`LDSS_X_HI:`LDSS_X_LO]),
		.fin_clear      (chain_phase_pulse[2]),
		.fin_load       (chain_phase_pulse[4]),
		.fin_src        (LDSS_SRC_WORD),
		.inc_load       (chain_phase_pulse[4]),
		.inc_src        (LDSS_SRC_POS),
		.add_complement (1'b1),
		.pos_inc        (1'b0),
		.pos_dec        (1'b0),
		.pos            (pos_x),
		.fin            (fin_x),
		.inc            (inc_x),
		.fin_eq_word    ()
	);

	ldss_section u_y (
		.clk_sys        (clk_sys),
		.rstn           (rstn),
		.word_field     (word_reg[`LDSS_Y_HI:`LDSS_Y_LO]),
		.fin_clear      (chain_phase_pulse[2]),
		.fin_load       (chain_phase_pulse[4]),
		.fin_src        (LDSS_SRC_WORD),
		.inc_load       (chain_phase_pulse[4]),
		.inc_src        (LDSS_SRC_POS),
		.add_complement (1'b1),
		.pos_inc        (1'b0),
		.pos_dec        (1'b0),
		.pos            (pos_y),
		.fin            (fin_y),
		.inc            (inc_y),
		.fin_eq_word    ()
	);

	// Zero-length test compares present position against the word halves
	assign x_eq = (pos_x == word_reg[`LDSS_X_HI:`LDSS_X_LO]);
	assign y_eq = (pos_y == word_reg[`LDSS_Y_HI:`LDSS_Y_LO]);
endmodule
`default_nettype wire

// >>> ldss_params.svh
`ifndef LDSS_PARAMS_SVH
`define LDSS_PARAMS_SVH

`define LDSS_CLK_HZ       200000000
`define LDSS_STEP_HZ      1000000
`define LDSS_STEP_DIV     (`LDSS_CLK_HZ / `LDSS_STEP_HZ)
`define LDSS_COORD_W      9
`define LDSS_WORD_W       18
`define LDSS_X_HI         17
`define LDSS_X_LO         9
`define LDSS_Y_HI         8
`define LDSS_Y_LO         0
`define LDSS_STAGES       5
`define LDSS_WC_W         16
`define LDSS_COORD_RST    9'h000
`define LDSS_WC_RST       16'h0000

`endif

// >>> ldss_pkg.sv
`default_nettype none
`include "ldss_params.svh"
package ldss_pkg;
	typedef logic [`LDSS_COORD_W-1:0] ldss_coord_t;
	typedef logic [`LDSS_WORD_W-1:0]  ldss_word_t;
	typedef logic [`LDSS_STAGES-1:0]  ldss_chain_t;
	typedef enum logic {LDSS_SRC_WORD, LDSS_SRC_SUM} ldss_fin_src_t;
	typedef enum logic {LDSS_SRC_POS, LDSS_SRC_ADD} ldss_inc_src_t;
endpackage
`default_nettype wire

// >>> ldss_section.sv
`default_nettype none
`include "ldss_params.svh"
module ldss_section (
	input  wire logic                   clk_sys,
	input  wire logic                   rstn,
	input  wire ldss_pkg::ldss_coord_t  word_field,
	input  wire logic                   fin_clear,
	input  wire logic                   fin_load,
	input  wire ldss_pkg::ldss_fin_src_t fin_src,
	input  wire logic                   inc_load,
	input  wire ldss_pkg::ldss_inc_src_t inc_src,
	input  wire logic                   add_complement,
	input  wire logic                   pos_inc,
	input  wire logic                   pos_dec,
	output var  ldss_pkg::ldss_coord_t  pos,
	output var  ldss_pkg::ldss_coord_t  fin,
	output var  ldss_pkg::ldss_coord_t  inc,
	output logic                        fin_eq_word
);
	import ldss_pkg::*;

	ldss_coord_t next_pos;
	ldss_coord_t next_fin;
	ldss_coord_t next_inc;
	ldss_coord_t operand;
	ldss_coord_t sum;

	always_comb begin
		operand = add_complement ? ~inc : inc;
		sum = fin + operand;
		fin_eq_word = (fin == word_field);
		next_fin = fin;
		if (fin_clear) begin
			next_fin = `LDSS_COORD_RST;
		end else if (fin_load) begin
			next_fin = (fin_src == LDSS_SRC_WORD) ? word_field : sum;
		end
		next_inc = inc;
		if (inc_load) begin
			next_inc = (inc_src == LDSS_SRC_POS) ? pos : sum;
		end
		next_pos = pos;
		if (pos_inc) begin
			next_pos = pos + 9'h001;
		end else if (pos_dec) begin
			next_pos = pos - 9'h001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pos <= `LDSS_COORD_RST;
			fin <= `LDSS_COORD_RST;
			inc <= `LDSS_COORD_RST;
		end else begin
			pos <= next_pos;
			fin <= next_fin;
			inc <= next_inc;
		end
	end
endmodule
`default_nettype wire

// >>> ldss_receiver.sv
`default_nettype none
`include "ldss_params.svh"
module ldss_receiver (
	input  wire logic                 clk_sys,
	input  wire logic                 rstn,
	input  wire logic                 send,
	input  wire ldss_pkg::ldss_word_t word,
	input  wire logic                 finished,
	output logic                      word_arrival,
	output ldss_pkg::ldss_word_t      word_in,
	output logic                      ready
);
	timeunit 1ns;
	timeprecision 100ps;
	import ldss_pkg::*;
	logic       next_word_arrival;
	logic       next_ready;
	ldss_word_t next_word_in;
	always_comb begin
		next_word_arrival = 1'b0;
		next_word_in = word_in;
		next_ready = ready;
		if (send && ready) begin
			// One strobe, only once the previous word has finished
			next_word_arrival = 1'b1;
			next_word_in = word;
			next_ready = 1'b0;
		end else if (finished) begin
			// Word is released here; invert it so a late load shows up
			next_word_in = ~word_in;
			next_ready = 1'b1;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			word_arrival <= 1'b0;
			word_in <= 18'h2d2d2;
			ready <= 1'b1;
		end else begin
			word_arrival <= next_word_arrival;
			word_in <= next_word_in;
			ready <= next_ready;
		end
	end
endmodule
`default_nettype wire

// >>> ldss_sequencer_checker.sv
`default_nettype none
`include "ldss_params.svh"
module ldss_sequencer_checker (
	input wire logic                    clk_sys,
	input wire logic                    rstn,
	input wire ldss_pkg::ldss_word_t    word_in,
	input wire logic                    line_mode,
	input wire logic                    char_mode,
	input wire logic                    write_mode,
	input wire logic                    hold_step,
	input wire logic                    repeat_step,
	input wire logic [`LDSS_STAGES-1:0] chain_phase_pulse,
	input wire logic                    seq_done,
	input wire logic                    char_start,
	input wire logic [`LDSS_WC_W-1:0]   word_counter,
	input wire logic                    panel_write,
	input wire logic                    panel_erase,
	input wire ldss_pkg::ldss_word_t    word_reg,
	input wire ldss_pkg::ldss_coord_t   pos_x,
	input wire ldss_pkg::ldss_coord_t   pos_y,
	input wire ldss_pkg::ldss_coord_t   fin_x,
	input wire ldss_pkg::ldss_coord_t   fin_y,
	input wire ldss_pkg::ldss_coord_t   inc_x
);
	timeunit 1ns;
	timeprecision 100ps;
	import ldss_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// Exact spacing only holds while hold_step stays low in stage 0
	sequence s_advance;
		##200 chain_phase_pulse[1];
	endsequence
	// A jump back from stage 3 shows stage 2 again one tick later
	sequence s_reenter;
		##200 chain_phase_pulse[2];
	endsequence
	property p_reset_clear;
		$rose(rstn) |-> chain_phase_pulse == '0 && word_counter == '0;
	endproperty
	property p_counter_bump;
		chain_phase_pulse[1] |=> word_counter == $past(word_counter) + 16'h0001;
	endproperty
	property p_panel_point;
		chain_phase_pulse[3] |=>
			panel_write == $past(write_mode) && panel_erase != $past(write_mode);
	endproperty
	property p_fin_load;
		chain_phase_pulse[4] |=>
			fin_x == $past(word_reg[`LDSS_X_HI:`LDSS_X_LO]) &&
			fin_y == $past(word_reg[`LDSS_Y_HI:`LDSS_Y_LO]) &&
			inc_x == $past(pos_x);
	endproperty
	property p_jump_back;
		chain_phase_pulse[3] && repeat_step && !hold_step |-> s_reenter;
	endproperty
	property p_plain_exit;
		chain_phase_pulse[4] && !hold_step && !line_mode && !char_mode |=> seq_done;
	endproperty
	property p_char_launch;
		chain_phase_pulse[4] && !hold_step && char_mode && !line_mode |=> char_start;
	endproperty
	property p_zero_len;
		chain_phase_pulse[4] && !hold_step && line_mode &&
			pos_x == word_reg[`LDSS_X_HI:`LDSS_X_LO] &&
			pos_y == word_reg[`LDSS_Y_HI:`LDSS_Y_LO] |=> seq_done;
	endproperty
	pulse_onehot_a: assert property ($onehot0(chain_phase_pulse))
		else $error("two step pulses at once");
	reset_clear_a: assert property (p_reset_clear)
		else $error("state left after reset");
	step_order_a: assert property (chain_phase_pulse[0] |-> s_advance)
		else $error("step 1 not one tick after step 0");
	word_load_a: assert property (chain_phase_pulse[0] |=> word_reg == $past(word_in))
		else $error("word not loaded at step 0");
	counter_bump_a: assert property (p_counter_bump)
		else $error("word counter not bumped");
	fin_clear_a: assert property (chain_phase_pulse[2] |=> fin_x == '0 && fin_y == '0)
		else $error("finals not cleared");
	panel_point_a: assert property (p_panel_point)
		else $error("wrong panel action");
	fin_load_a: assert property (p_fin_load)
		else $error("step 4 loads wrong");
	jump_back_a: assert property (p_jump_back)
		else $error("stage 3 did not return to stage 2");
	plain_exit_a: assert property (p_plain_exit)
		else $error("plain word did not end at step 4");
	char_launch_a: assert property (p_char_launch)
		else $error("character sequence not launched at step 4");
	zero_len_a: assert property (p_zero_len)
		else $error("zero-length line did not end at step 4");
endmodule
bind ldss_sequencer ldss_sequencer_checker u_ldss_sequencer_checker (.clk_sys(clk_sys),
	.rstn(rstn), .word_in(word_in), .line_mode(line_mode), .char_mode(char_mode),
	.write_mode(write_mode), .hold_step(hold_step), .repeat_step(repeat_step),
	.chain_phase_pulse(chain_phase_pulse), .seq_done(seq_done), .char_start(char_start),
	.word_counter(word_counter), .panel_write(panel_write), .panel_erase(panel_erase),
	.word_reg(word_reg), .pos_x(pos_x), .pos_y(pos_y), .fin_x(fin_x), .fin_y(fin_y),
	.inc_x(inc_x));
`default_nettype wire

// >>> tb_line_draw_setup_sequencer.sv
`default_nettype none
`include "ldss_params.svh"
module tb_line_draw_setup_sequencer;
	timeunit 1ns;
	timeprecision 100ps;
	import ldss_pkg::*;
	logic clk_sys = 0, rstn = 0, send = 0, line_mode = 0, char_mode = 0, write_mode = 0;
	logic hold_step = 0, repeat_step = 0, word_arrival, ready, busy, seq_done, word_error;
	logic panel_write, panel_erase, char_start, line_start;
	logic [4:0] chain_phase_pulse, seen;
	logic [15:0] word_counter, exp_wc;
	ldss_word_t word = 0, word_in, word_reg, lf = 18'h32;
	ldss_coord_t pos_x, pos_y, fin_x, fin_y, inc_x, inc_y;
	int n_fail = 0, checked = 0, cyc = 0;
	always #2.5 clk_sys = ~clk_sys;
	ldss_receiver u_ldss_receiver (.clk_sys(clk_sys), .rstn(rstn), .send(send), .word(word),
		.finished(seq_done | line_start | char_start), .word_arrival(word_arrival),
		.word_in(word_in), .ready(ready));
	ldss_sequencer u_ldss_sequencer (.clk_sys(clk_sys), .rstn(rstn), .word_arrival(word_arrival),
		.word_in(word_in), .line_mode(line_mode), .char_mode(char_mode), .write_mode(write_mode),
		.hold_step(hold_step), .repeat_step(repeat_step), .busy(busy),
		.chain_phase_pulse(chain_phase_pulse), .seq_done(seq_done), .word_error(word_error),
		.word_counter(word_counter), .panel_write(panel_write), .panel_erase(panel_erase),
		.char_start(char_start), .line_start(line_start), .word_reg(word_reg), .pos_x(pos_x),
		.pos_y(pos_y), .fin_x(fin_x), .fin_y(fin_y), .inc_x(inc_x), .inc_y(inc_y));
	function automatic ldss_word_t lfsr(input ldss_word_t s);
		return {s[16:0], s[17] ^ s[10]};
	endfunction
	task automatic wrap_up();
		if (n_fail == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
		checked++;
		if (exp !== got) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic do_reset();
		rstn <= 1'b0;
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
		exp_wc = 16'h0000;
	endtask
	task automatic run_word(input ldss_word_t w, input logic lm, cm, wm, hold);
		int hc;
		logic [2:0] endk;
		logic [1:0] pw;
		int rc;
		logic rep_done;
		logic [2:0] exp_end;
		hc = 0;
		rc = 0;
		rep_done = 1'b0;
		endk = 3'b000;
		pw = 2'b00;
		@(posedge clk_sys);
		send <= 1'b1;
		word <= w;
		line_mode <= lm;
		char_mode <= cm;
		write_mode <= wm;
		@(posedge clk_sys);
		send <= 1'b0;
		for (int k = 0; k < 2000 && endk == 3'b000; k++) begin
			@(posedge clk_sys);
			hold_step <= (hc > 0);
			repeat_step <= (rc > 0);
			#1;
			if (hc > 0) hc--;
			if (rc > 0) rc--;
			// Held across one tick while the token sits in stage 2
			if (hold && chain_phase_pulse[1] === 1'b1) hc = 300;
			// Line words without a hold are sent back once from stage 3 to stage 2
			if (!hold && lm && !rep_done && chain_phase_pulse[2] === 1'b1) begin
				rc = 200;
				rep_done = 1'b1;
			end
			pw = pw | {panel_write, panel_erase};
			endk = {char_start, line_start, seq_done};
		end
		exp_wc = exp_wc + 16'h0001;
		exp_end = lm ? ((w != 0) ? 3'h2 : 3'h1) : (cm ? 3'h4 : 3'h1);
		chk("end", exp_end, endk);
		chk("panel", {wm, !wm}, pw);
		chk("word_reg", w, word_reg);
		chk("word_counter", exp_wc, word_counter);
		chk("fin_x", w[17:9], fin_x);
		chk("fin_y", w[8:0], fin_y);
		chk("inc", 18'h0, {inc_x, inc_y});
		chk("word_error", lm && cm, word_error);
		chk("busy", 18'h0, busy);
		chk("pos", 18'h0, {pos_x, pos_y});
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_fail++;
			$display("Error cycles expected below %0d seen %0d", 30000, cyc);
			wrap_up();
		end
	end
	initial begin
		do_reset();
		run_word(18'h0a5c3, 1'b0, 1'b0, 1'b1, 1'b0);
		run_word(18'h12345, 1'b1, 1'b0, 1'b1, 1'b1);
		run_word(18'h00000, 1'b1, 1'b0, 1'b0, 1'b0);
		run_word(18'h3fe01, 1'b0, 1'b1, 1'b1, 1'b0);
		for (int i = 0; i < 4; i++) begin
			lf = lfsr(lf);
			run_word(lf, !lf[0], lf[0], lf[1], lf[2]);
		end
		run_word(18'h2aa55, 1'b1, 1'b1, 1'b0, 1'b0);
		@(posedge clk_sys);
		do_reset();
		seen = 5'h00;
		repeat (400) begin
			@(posedge clk_sys);
			#1;
			seen = seen | chain_phase_pulse;
		end
		chk("idle pulses", 18'h0, seen);
		chk("word_counter", 18'h0, word_counter);
		run_word(18'h1ff00, 1'b1, 1'b0, 1'b1, 1'b0);
		wrap_up();
	end
endmodule
`default_nettype wire
